/* File: hdl/frh_top.sv */
// Fieldbus remote output handler: run bits, terminals and handshakes
`timescale 1ns/10ps
module frh_top (
  input wire logic clock,
  input wire logic rst,
  // Cyclic remote output bits from the master
  input wire logic [frh_pkg::REQ_W-1:0] remote_out_bits,
  // Remote write words
  input wire logic [frh_pkg::WORD_W-1:0] freq_reference_word,
  input wire logic [frh_pkg::CMD_WORDS-1:0][frh_pkg::WORD_W-1:0] command_code_word,
  // Monitored values from the drive core
  input wire logic [frh_pkg::MON_WORDS-1:0][frh_pkg::WORD_W-1:0] monitor_values,
  // Trip indication from the drive core
  input wire logic trip_event,
  // Command executor of the drive core
  output logic exe_valid,
  output logic [frh_pkg::WORD_W-1:0] exe_code,
  input wire logic exe_ack,
  input wire logic exe_err,
  input wire logic [frh_pkg::WORD_W-1:0] exe_cause,
  // Drive commands
  output logic run_forward,
  output logic run_reverse,
  output logic zero_freq,
  output logic coast_stop,
  output logic [2:0] multistep_select,
  output logic [frh_pkg::WORD_W-1:0] speed_reference,
  output logic trip_clear,
  // Remote read side
  output logic [frh_pkg::MON_WORDS-1:0][frh_pkg::WORD_W-1:0] monitor_read_words,
  output logic [frh_pkg::WORD_W-1:0] response_code_word,
  output logic monitor_done_flag,
  output logic freq_set_done_flag,
  output logic cmd_exec_done_flag,
  output logic alarm_reset_flag,
  // Register port
  input wire logic [frh_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // Named views of the request bits; the unused positions are never
  // looked at, so the master may toggle them freely
  logic fwd_run_request;
  logic rev_run_request;
  logic [frh_pkg::TERM_CNT-1:0] term_bits;
  logic output_cutoff_request;
  logic monitor_request;
  logic freq_write_request;
  logic cmd_exec_request;
  logic alarm_reset_request;

  assign fwd_run_request = remote_out_bits[frh_pkg::FWD_RUN_POS];
  assign rev_run_request = remote_out_bits[frh_pkg::REV_RUN_POS];
  assign term_bits = remote_out_bits[frh_pkg::TERM_BASE_POS +: frh_pkg::TERM_CNT];
  assign output_cutoff_request = remote_out_bits[frh_pkg::CUTOFF_POS];
  assign monitor_request = remote_out_bits[frh_pkg::MONITOR_POS];
  assign freq_write_request = remote_out_bits[frh_pkg::FREQ_WRITE_POS];
  assign cmd_exec_request = remote_out_bits[frh_pkg::CMD_EXEC_POS];
  assign alarm_reset_request = remote_out_bits[frh_pkg::ALARM_RESET_POS];

  // Software registers
  logic [0:0] ctrl_q; // Run source select
  logic [19:0] termfn_q; // Five 4-bit function codes
  logic [frh_pkg::IRQ_W-1:0] irq_stat_q; // Sticky events
  logic [frh_pkg::IRQ_W-1:0] irq_mask_q; // Interrupt enables
  logic net_run_src; // Run command comes from the network

  assign net_run_src = ctrl_q[frh_pkg::CTRL_NET_RUN_POS];

  // Previous request levels for edge detection
  logic mon_req_q;
  logic freq_req_q;
  logic cmd_req_q;
  logic alarm_req_q;
  logic alarm_req_any; // Network request or terminal trip reset

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mon_req_q <= 1'b0;
      freq_req_q <= 1'b0;
      cmd_req_q <= 1'b0;
      alarm_req_q <= 1'b0;
    end else begin
      mon_req_q <= monitor_request;
      freq_req_q <= freq_write_request;
      cmd_req_q <= cmd_exec_request;
      alarm_req_q <= alarm_req_any;
    end
  end

  logic mon_rise;
  logic freq_rise;
  logic cmd_rise;
  assign mon_rise = monitor_request & ~mon_req_q;
  assign freq_rise = freq_write_request & ~freq_req_q;
  assign cmd_rise = cmd_exec_request & ~cmd_req_q;

  // Terminal function mapping
  logic [2:0] term_multistep;
  logic term_coast;
  logic term_trip_reset;

  frh_term_map #(
    .N(frh_pkg::TERM_CNT)
  ) u_term_map (
    .clock(clock),
    .rst(rst),
    .term_bits(term_bits),
    .term_codes(termfn_q),
    .multistep_select(term_multistep),
    .coast_stop(term_coast),
    .trip_reset(term_trip_reset)
  );

  // Run command decode; the network run bits only count when the
  // network owns the run command
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
      zero_freq <= 1'b0;
    end else begin
      run_forward <= net_run_src & fwd_run_request;
      run_reverse <= net_run_src & rev_run_request;
      // Both directions at once hold the output at zero frequency
      zero_freq <= net_run_src & fwd_run_request & rev_run_request;
    end
  end

  // Coast stop from the cutoff bit or a terminal set to coast
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      coast_stop <= 1'b0;
      multistep_select <= 3'h0;
    end else begin
      coast_stop <= (output_cutoff_request & net_run_src) | term_coast;
      multistep_select <= term_multistep;
    end
  end

  // Monitor capture: load on the rise, keep refreshing while held
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      monitor_read_words <= '0;
    end else if (monitor_request) begin
      monitor_read_words <= monitor_values;
    end
  end

  // Done follows the first load by one cycle and drops with the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      monitor_done_flag <= 1'b0;
    end else begin
      monitor_done_flag <= monitor_request & (monitor_done_flag | mon_req_q);
    end
  end

  // Frequency reference: copied on the rise and tracked while held,
  // the last copy stays applied once the request drops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      speed_reference <= 16'h0000;
    end else if (freq_write_request) begin
      speed_reference <= freq_reference_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      freq_set_done_flag <= 1'b0;
    end else begin
      freq_set_done_flag <= freq_write_request & (freq_set_done_flag | freq_req_q);
    end
  end

  // Command execution through the sequencer
  frh_cmd_if cif ();

  assign cif.start = cmd_rise;
  assign cif.words = command_code_word;
  assign cif.exe_ack = exe_ack;
  assign cif.exe_err = exe_err;
  assign cif.exe_cause = exe_cause;
  assign exe_valid = cif.exe_valid;
  assign exe_code = cif.exe_code;

  frh_cmd_seq u_cmd_seq (
    .clock(clock),
    .rst(rst),
    .cif(cif)
  );

  // Done set wins over the clear caused by a dropped request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_exec_done_flag <= 1'b0;
    end else begin
      cmd_exec_done_flag <= cif.done | (cmd_exec_done_flag & cmd_exec_request);
    end
  end

  // Response code: cleared on a new start, loaded with the cause on error
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      response_code_word <= 16'h0000;
    end else if (cmd_rise && !cif.busy) begin
      response_code_word <= 16'h0000;
    end else if (cif.done) begin
      response_code_word <= cif.err ? cif.cause : 16'h0000;
    end
  end

  // Alarm reset: a request seen high during a trip arms the reset, and
  // its release clears the trip. A master holding the bit never clears.
  logic alarm_armed_q; // High seen while tripped
  logic alarm_fall;

  assign alarm_req_any = alarm_reset_request | term_trip_reset;
  assign alarm_fall = alarm_req_q & ~alarm_req_any;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_armed_q <= 1'b0;
    end else if (alarm_fall) begin
      alarm_armed_q <= 1'b0;
    end else if (alarm_req_any && alarm_reset_flag) begin
      alarm_armed_q <= 1'b1;
    end
  end

  // Trip state; a new trip in the clearing cycle wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_reset_flag <= 1'b0;
      trip_clear <= 1'b0;
    end else begin
      trip_clear <= alarm_fall & alarm_armed_q & ~trip_event;
      if (trip_event) begin
        alarm_reset_flag <= 1'b1;
      end else if (alarm_fall && alarm_armed_q) begin
        alarm_reset_flag <= 1'b0;
      end
    end
  end

  // Interrupt events, one-cycle each except the trip, which lasts as long as trip_event
  logic [frh_pkg::IRQ_W-1:0] irq_evt;
  always_comb begin
    irq_evt = '0;
    irq_evt[frh_pkg::IRQ_MON] = mon_req_q & monitor_request & ~monitor_done_flag;
    irq_evt[frh_pkg::IRQ_FREQ] = freq_req_q & freq_write_request & ~freq_set_done_flag;
    irq_evt[frh_pkg::IRQ_CMD] = cif.done;
    irq_evt[frh_pkg::IRQ_CMD_ERR] = cif.done & cif.err;
    irq_evt[frh_pkg::IRQ_TRIP_CLR] = alarm_fall & alarm_armed_q & ~trip_event;
    irq_evt[frh_pkg::IRQ_TRIP] = trip_event;
  end

  // Write decode strobes
  logic wr_ctrl;
  logic wr_termfn;
  logic wr_stat;
  logic wr_mask;
  always_comb begin
    wr_ctrl = 1'b0;
    wr_termfn = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (reg_wr && reg_addr == frh_pkg::REG_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && reg_addr == frh_pkg::REG_TERMFN) begin
      wr_termfn = 1'b1;
    end else if (reg_wr && reg_addr == frh_pkg::REG_IRQ_STAT) begin
      wr_stat = 1'b1;
    end else if (reg_wr && reg_addr == frh_pkg::REG_IRQ_MASK) begin
      wr_mask = 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= frh_pkg::CTRL_RESET;
      termfn_q <= frh_pkg::TERMFN_RESET;
      irq_mask_q <= frh_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[0:0];
      end
      if (wr_termfn) begin
        termfn_q <= reg_wdata[19:0];
      end
      if (wr_mask) begin
        irq_mask_q <= reg_wdata[frh_pkg::IRQ_W-1:0];
      end
    end
  end

  // Sticky status: write one to clear, a new event wins over the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_evt | (irq_stat_q & ~(wr_stat ? reg_wdata[frh_pkg::IRQ_W-1:0] : '0));
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Live status word
  logic [31:0] status_word;
  assign status_word = {22'h000000, cif.busy, cmd_exec_done_flag, freq_set_done_flag,
                        monitor_done_flag, alarm_reset_flag, coast_stop, zero_freq,
                        run_reverse, run_forward, 1'b0};

  // Read data stand in the cycle after the read strobe only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == frh_pkg::REG_CTRL) begin
      reg_rdata <= {31'h00000000, ctrl_q};
    end else if (reg_addr == frh_pkg::REG_TERMFN) begin
      reg_rdata <= {12'h000, termfn_q};
    end else if (reg_addr == frh_pkg::REG_STATUS) begin
      reg_rdata <= status_word;
    end else if (reg_addr == frh_pkg::REG_IRQ_STAT) begin
      reg_rdata <= {26'h0000000, irq_stat_q};
    end else if (reg_addr == frh_pkg::REG_IRQ_MASK) begin
      reg_rdata <= {26'h0000000, irq_mask_q};
    end else if (reg_addr == frh_pkg::REG_RESPONSE) begin
      reg_rdata <= {16'h0000, response_code_word};
    end else begin
      reg_rdata <= 32'h00000000; // Unmapped reads return zero
    end
  end

endmodule : frh_top

/* File: hdl/frh_pkg.sv */
// Constants, types and register map of the fieldbus remote output handler
// Overview of operation
// - Forward request set runs forward, else stop
// - Reverse request set runs reverse, else stop
// - Both run requests set command zero frequency
// - Bits two to six drive five terminal functions
// - Terminal functions not network operable are ignored
// - Cutoff coasts motor, only with network run source
// - Monitor request rise loads words, then done
// - Monitored words refresh while monitor request held
// - Frequency request rise stores reference, then done
// - Held frequency request keeps applying reference word
// - Command request rise executes six words, then done
// - Failed command places cause in response code
// - Commands execute once per request rising edge; a rise while the sequencer is busy is ignored
// - Alarm reset on then off clears trip
package frh_pkg;

  // Remote output bit positions
  localparam int REQ_W = 32;
  localparam int FWD_RUN_POS = 0;
  localparam int REV_RUN_POS = 1;
  localparam int TERM_BASE_POS = 2;
  localparam int CUTOFF_POS = 9;
  localparam int MONITOR_POS = 12;
  localparam int FREQ_WRITE_POS = 13;
  localparam int CMD_EXEC_POS = 15;
  localparam int ALARM_RESET_POS = 26;

  // Word sizes and counts
  localparam int WORD_W = 16;
  localparam int TERM_CNT = 5;
  localparam int MON_WORDS = 6;
  localparam int CMD_WORDS = 6;
  localparam int FN_W = 4;

  // Terminal function codes
  typedef enum logic [3:0] {
    FN_MULTISTEP_A = 4'h0,
    FN_MULTISTEP_B = 4'h1,
    FN_MULTISTEP_C = 4'h2,
    FN_COAST_STOP = 4'h3,
    FN_TRIP_RESET = 4'h4,
    FN_LOCAL_ONLY = 4'h5
  } frh_func_e;

  // Default codes: five terminals from first to fifth
  localparam logic [19:0] TERMFN_RESET = 20'h43210;

  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TERMFN = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_RESPONSE = 8'h14;

  // Control register: bit 0 says the run command comes from the network
  localparam int CTRL_NET_RUN_POS = 0;
  localparam logic [0:0] CTRL_RESET = 1'h1;

  // Interrupt bits
  localparam int IRQ_W = 6;
  localparam int IRQ_MON = 0;
  localparam int IRQ_FREQ = 1;
  localparam int IRQ_CMD = 2;
  localparam int IRQ_CMD_ERR = 3;
  localparam int IRQ_TRIP_CLR = 4;
  localparam int IRQ_TRIP = 5;
  localparam logic [5:0] IRQ_MASK_RESET = 6'h00;

  // Command sequencer states
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_ISSUE = 2'b01,
    CMD_WAIT = 2'b10,
    CMD_FINISH = 2'b11
  } frh_cmd_state_e;

endpackage : frh_pkg

/* File: hdl/frh_cmd_if.sv */
// Carrier between the handler top and its command sequencer
`timescale 1ns/10ps
interface frh_cmd_if;
  logic start;                                             // One-cycle start
  logic [frh_pkg::CMD_WORDS-1:0][frh_pkg::WORD_W-1:0] words; // Command codes
  logic exe_valid;                                         // Code offered to drive
  logic [frh_pkg::WORD_W-1:0] exe_code;                    // Code being offered
  logic exe_ack;                                           // Drive accepted code
  logic exe_err;                                           // Drive reported failure
  logic [frh_pkg::WORD_W-1:0] exe_cause;                   // Failure cause
  logic done;                                              // One-cycle finish
  logic err;                                               // Any word failed
  logic [frh_pkg::WORD_W-1:0] cause;                       // First failure cause
  logic busy;                                              // Sequence running

  modport seq (
    input start, words, exe_ack, exe_err, exe_cause,
    output exe_valid, exe_code, done, err, cause, busy
  );
  modport top (
    output start, words, exe_ack, exe_err, exe_cause,
    input exe_valid, exe_code, done, err, cause, busy
  );
endinterface : frh_cmd_if

/* File: hdl/frh_term_map.sv */
// Maps the five terminal bits onto their configured drive functions
`timescale 1ns/10ps
module frh_term_map #(
  parameter int N = frh_pkg::TERM_CNT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [N-1:0] term_bits,
  input wire logic [N-1:0][frh_pkg::FN_W-1:0] term_codes,
  output logic [2:0] multistep_select,
  output logic coast_stop,
  output logic trip_reset
);

  // One-hot of {trip reset, coast, select c, select b, select a}
  function automatic logic [4:0] fn_decode(input logic [3:0] code);
    logic [4:0] hot;
    hot = 5'h00;
    case (code)
      frh_pkg::FN_MULTISTEP_A: hot = 5'h01;
      frh_pkg::FN_MULTISTEP_B: hot = 5'h02;
      frh_pkg::FN_MULTISTEP_C: hot = 5'h04;
      frh_pkg::FN_COAST_STOP: hot = 5'h08;
      frh_pkg::FN_TRIP_RESET: hot = 5'h10;
      default: hot = 5'h00; // Local-only functions give nothing
    endcase
    return hot;
  endfunction : fn_decode

  logic [N-1:0][4:0] hit; // Per-terminal function hits

  // Each terminal bit is steered by its own function code
  generate
    for (genvar i = 0; i < N; i++) begin : g_term
      assign hit[i] = term_bits[i] ? fn_decode(term_codes[i]) : 5'h00;
    end
  endgenerate

  logic [4:0] any_d; // Combined hits

  // Several terminals may share a function, so the hits are ORed
  always_comb begin
    logic [4:0] acc;
    acc = 5'h00;
    for (int i = 0; i < N; i++) begin
      acc = acc | hit[i];
    end
    any_d = acc;
  end

  // Outputs come from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      multistep_select <= 3'h0;
      coast_stop <= 1'b0;
      trip_reset <= 1'b0;
    end else begin
      multistep_select <= any_d[2:0];
      coast_stop <= any_d[3];
      trip_reset <= any_d[4];
    end
  end

endmodule : frh_term_map

/* File: hdl/frh_cmd_seq.sv */
// Walks the six command code words through the drive's command executor
`timescale 1ns/10ps
module frh_cmd_seq (
  input wire logic clock,
  input wire logic rst,
  frh_cmd_if.seq cif
);

  frh_pkg::frh_cmd_state_e state_q; // Sequencer state
  logic [2:0] idx_q; // Word being executed
  logic err_q; // Any failure seen this run
  logic [frh_pkg::WORD_W-1:0] cause_q; // First failure cause
  logic [frh_pkg::WORD_W-1:0] code_q; // Code offered to the drive

  assign cif.exe_valid = (state_q == frh_pkg::CMD_WAIT);
  assign cif.exe_code = code_q;
  assign cif.done = (state_q == frh_pkg::CMD_FINISH);
  assign cif.err = err_q;
  assign cif.cause = cause_q;
  assign cif.busy = (state_q != frh_pkg::CMD_IDLE);

  // Each start seen in idle runs every word exactly once, in order; a start while busy is dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= frh_pkg::CMD_IDLE;
      idx_q <= 3'h0;
      code_q <= 16'h0000;
    end else begin
      case (state_q)
        frh_pkg::CMD_IDLE: begin
          idx_q <= 3'h0;
          if (cif.start) begin
            state_q <= frh_pkg::CMD_ISSUE;
          end
        end
        frh_pkg::CMD_ISSUE: begin
          code_q <= cif.words[idx_q];
          state_q <= frh_pkg::CMD_WAIT;
        end
        frh_pkg::CMD_WAIT: begin
          if (cif.exe_ack) begin
            if (idx_q == 3'(frh_pkg::CMD_WORDS - 1)) begin
              state_q <= frh_pkg::CMD_FINISH;
            end else begin
              idx_q <= idx_q + 3'h1;
              state_q <= frh_pkg::CMD_ISSUE;
            end
          end
        end
        default: state_q <= frh_pkg::CMD_IDLE;
      endcase
    end
  end

  // Error capture: first failing word's cause is kept
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
      cause_q <= 16'h0000;
    end else if (state_q == frh_pkg::CMD_IDLE && cif.start) begin
      err_q <= 1'b0;
      cause_q <= 16'h0000;
    end else if (state_q == frh_pkg::CMD_WAIT && cif.exe_ack && cif.exe_err && !err_q) begin
      err_q <= 1'b1;
      cause_q <= cif.exe_cause;
    end
  end

endmodule : frh_cmd_seq

/* File: verif/frh_checker.sv */
// Port-level checker for the remote output handler
`timescale 1ns/10ps
module frh_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [frh_pkg::REQ_W-1:0] remote_out_bits,
  input wire logic [frh_pkg::WORD_W-1:0] freq_reference_word,
  input wire logic [frh_pkg::MON_WORDS-1:0][frh_pkg::WORD_W-1:0] monitor_values,
  input wire logic run_forward,
  input wire logic run_reverse,
  input wire logic zero_freq,
  input wire logic coast_stop,
  input wire logic [frh_pkg::WORD_W-1:0] speed_reference,
  input wire logic [frh_pkg::MON_WORDS-1:0][frh_pkg::WORD_W-1:0] monitor_read_words,
  input wire logic monitor_done_flag,
  input wire logic freq_set_done_flag,
  input wire logic cmd_exec_done_flag,
  input wire logic [frh_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr
);
  // One domain, so one clock and one disable for all
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic net_q; // Run source mirror
  always_ff @(posedge clock or posedge rst)
    if (rst) net_q <= frh_pkg::CTRL_RESET;
    else if (reg_wr && reg_addr == frh_pkg::REG_CTRL) net_q <= reg_wdata[0];
  AST_FWD: assert property (!remote_out_bits[1] |=>
    run_forward == ($past(remote_out_bits[0]) && $past(net_q)))
    else $error("forward run does not follow its request");
  AST_REV: assert property (!remote_out_bits[0] |=>
    run_reverse == ($past(remote_out_bits[1]) && $past(net_q)))
    else $error("reverse run does not follow its request");
  AST_ZERO: assert property (remote_out_bits[0] && remote_out_bits[1] |=> zero_freq)
    else $error("both run requests without zero frequency");
  AST_CUT: assert property (remote_out_bits[9] && net_q |=> coast_stop)
    else $error("cutoff request did not coast");
  AST_MON_DONE: assert property ($rose(remote_out_bits[12]) |-> ##[1:3] monitor_done_flag)
    else $error("monitor done flag late");
  AST_MON_WORDS: assert property (remote_out_bits[12] |=>
    monitor_read_words == $past(monitor_values))
    else $error("monitor words not refreshed");
  AST_FREQ_DONE: assert property ($rose(remote_out_bits[13]) |->
    ##[1:3] freq_set_done_flag)
    else $error("frequency done flag late");
  AST_SPEED: assert property (remote_out_bits[13] |=>
    speed_reference == $past(freq_reference_word))
    else $error("speed reference not tracking");
  AST_MON_DROP: assert property (!remote_out_bits[12] |=> !monitor_done_flag)
    else $error("monitor done flag stuck");
  AST_CMD_DROP: assert property (!remote_out_bits[15] |=> !cmd_exec_done_flag)
    else $error("command done flag stuck");
endmodule : frh_checker

bind frh_top frh_checker u_chk (.clock, .rst, .remote_out_bits, .freq_reference_word,
  .monitor_values, .run_forward, .run_reverse, .zero_freq, .coast_stop, .speed_reference,
  .monitor_read_words, .monitor_done_flag, .freq_set_done_flag, .cmd_exec_done_flag,
  .reg_addr, .reg_wdata, .reg_wr);

/* File: verif/frh_exec_model.sv */
// Drive-core command executor seen from the handler
`timescale 1ns/10ps
module frh_exec_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire logic [15:0] fail_code,
  input wire logic exe_valid,
  input wire logic [15:0] exe_code,
  output logic exe_ack,
  output logic exe_err,
  output logic [15:0] exe_cause
);
  logic [1:0] wait_q; // Stall count while slow
  // Accept each offered code, after a stall when slow
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exe_ack <= 1'h0;
      wait_q <= 2'h0;
    end else if (exe_ack) begin
      exe_ack <= 1'h0;
    end else if (exe_valid && (!slow || wait_q == 2'h3)) begin
      exe_ack <= 1'h1;
      wait_q <= 2'h0;
    end else if (exe_valid) begin
      wait_q <= wait_q + 2'h1;
    end
  end
  // Failure only on the code the bench names; cause is the code inverted
  assign exe_err = exe_ack && exe_code == fail_code;
  assign exe_cause = ~exe_code;
endmodule : frh_exec_model

/* File: verif/tb_frh_top.sv */
// Self-checking bench for the remote output handler
`timescale 1ns/10ps
module tb_frh_top;
  logic clock = 0, rst = 1, trip = 0, reg_wr = 0, reg_rd = 0, slow = 0;
  logic [31:0] rob = '0, reg_wdata = '0, reg_rdata;
  logic [15:0] frw = '0, fail_code = 16'hFFFF, exe_code, exe_cause;
  logic [15:0] speed_reference, response_code_word;
  logic [5:0][15:0] ccw = '0, mv = '0, monitor_read_words;
  logic [7:0] reg_addr = '0;
  logic [2:0] multistep_select;
  logic exe_valid, exe_ack, exe_err, run_forward, run_reverse, zero_freq, coast_stop;
  logic trip_clear, monitor_done_flag, freq_set_done_flag, cmd_exec_done_flag;
  logic alarm_reset_flag, irq;
  int err_total = 0, checks_done = 0, cyc = 0, acks = 0, clrs = 0;
  frh_top DUT (.clock, .rst, .remote_out_bits(rob), .freq_reference_word(frw),
    .command_code_word(ccw), .monitor_values(mv), .trip_event(trip), .exe_valid,
    .exe_code, .exe_ack, .exe_err, .exe_cause, .run_forward, .run_reverse, .zero_freq,
    .coast_stop, .multistep_select, .speed_reference, .trip_clear, .monitor_read_words,
    .response_code_word, .monitor_done_flag, .freq_set_done_flag, .cmd_exec_done_flag,
    .alarm_reset_flag, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  frh_exec_model u_exec (.clock, .rst, .slow, .fail_code, .exe_valid, .exe_code,
    .exe_ack, .exe_err, .exe_cause);
  always #25 clock = ~clock;
  // Handshake and pulse counters, plus the hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (exe_valid && exe_ack) acks <= acks + 1;
    if (trip_clear) clrs <= clrs + 1;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize;
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc_n
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(posedge clock);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic t_run;
    for (int i = 0; i < 4; i++) begin
      rob <= 32'h00004D80 | i; // Idle bits set as junk
      cyc_n(2);
      chk(zero_freq, i == 3);
      if (i < 3) chk({run_reverse, run_forward}, i);
    end
  endtask : t_run
  task automatic t_term;
    rob <= 32'h00000014; // Terminals one and three
    cyc_n(3);
    chk(multistep_select, 3'h5);
    wr(frh_pkg::REG_TERMFN, 32'h00043215);
    cyc_n(3);
    chk(multistep_select, 3'h4);
    rob <= 32'h00000020;
    cyc_n(3);
    chk(coast_stop, 1'h1);
    rob <= 32'h00000200; // Terminal path has two flops, so wait it out
    cyc_n(4);
    chk(coast_stop, 1'h1);
    wr(frh_pkg::REG_CTRL, 32'h00000000);
    cyc_n(2);
    chk(coast_stop, 1'h0);
    wr(frh_pkg::REG_CTRL, 32'h00000001);
  endtask : t_term
  task automatic t_mon;
    mv <= 96'h666655554444333322221111;
    rob <= 32'h00001000;
    cyc_n(3);
    chk(monitor_done_flag, 1'h1);
    chk(monitor_read_words[5], 16'h6666);
    mv[5] <= 16'hABCD;
    cyc_n(2);
    chk(monitor_read_words[5], 16'hABCD);
    rob <= '0;
    cyc_n(2);
    chk(monitor_done_flag, 1'h0);
  endtask : t_mon
  task automatic t_freq;
    frw <= 16'h1234;
    rob <= 32'h00002000;
    cyc_n(3);
    chk(freq_set_done_flag, 1'h1);
    chk(speed_reference, 16'h1234);
    frw <= 16'h0F0F;
    cyc_n(2);
    chk(speed_reference, 16'h0F0F);
    rob <= '0;
    cyc_n(2);
    chk(freq_set_done_flag, 1'h0);
  endtask : t_freq
  task automatic t_cmd(input int runs);
    ccw <= 96'h010601050104010301020101;
    fail_code <= 16'h0104;
    slow <= runs == 6;
    rob <= 32'h00008000;
    for (int i = 0; i < 80 && !cmd_exec_done_flag; i++) @(posedge clock);
    chk(response_code_word, 16'hFEFB);
    cyc_n(20);
    chk(acks, runs);
    rob <= '0;
    cyc_n(2);
    chk(cmd_exec_done_flag, 1'h0);
  endtask : t_cmd
  task automatic t_alarm;
    trip <= 1'h1;
    cyc_n(1);
    trip <= 1'h0;
    cyc_n(2);
    chk(alarm_reset_flag, 1'h1);
    rob <= 32'h04000000; // Pulse on then off
    cyc_n(2);
    rob <= '0;
    cyc_n(3);
    chk(alarm_reset_flag, 1'h0);
    chk(clrs, 1);
  endtask : t_alarm
  task automatic t_irq;
    wr(frh_pkg::REG_IRQ_MASK, 32'h0000003F);
    cyc_n(1);
    chk(irq, 1'h1);
    wr(frh_pkg::REG_IRQ_MASK, 32'h00000000);
    rd(frh_pkg::REG_IRQ_STAT, 32'h0000003F);
    chk(irq, 1'h0);
    wr(frh_pkg::REG_IRQ_STAT, 32'h0000003F);
    wr(frh_pkg::REG_IRQ_MASK, 32'h0000003F);
    rd(frh_pkg::REG_IRQ_STAT, 32'h00000000);
    chk(irq, 1'h0);
    rd(8'h3C, 32'h00000000);
  endtask : t_irq
  initial begin
    cyc_n(3);
    rst <= 1'h0;
    rd(frh_pkg::REG_CTRL, 32'h00000001);
    rd(frh_pkg::REG_TERMFN, 32'h00043210);
    t_run();
    t_term();
    t_mon();
    t_freq();
    t_cmd(6);
    t_cmd(12);
    t_alarm();
    t_irq();
    summarize();
  end
endmodule : tb_frh_top
